// ### common/dlatch_pkg.sv
// Purpose: Shared constants and types for the digital input latch block
// Assumes: Wishbone classic slave, 32-bit data, 16-bit setting words
// Notes:   Each setting word holds four hex digits; digit 0 is the lowest nibble
package dlatch_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned WORD_W = 16;
   // Register byte offsets
   localparam logic [7:0] OFS_CH4_POL  = 8'h00;
   localparam logic [7:0] OFS_CH4_FUNC = 8'h04;
   localparam logic [7:0] OFS_CH5_POL  = 8'h08;
   localparam logic [7:0] OFS_CH5_FUNC = 8'h0c;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_MASK     = 8'h14;
   localparam logic [7:0] OFS_LEVEL    = 8'h18;
   // Field positions inside a setting word
   localparam int unsigned POL_BIT  = 0;
   localparam int unsigned FUNC_BIT = 0;
   localparam int unsigned EDGE_BIT = 4;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [1:0]  EV_RST   = 2'h0;
   // Status/mask bit positions
   localparam int unsigned EV_CH4 = 0;
   localparam int unsigned EV_CH5 = 1;

   typedef struct packed {
      logic pol;
      logic latch;
      logic fall;
   } chan_cfg_t;
endpackage : dlatch_pkg

// ### rtl/digital_input_latch_config.sv
// Purpose: Two field inputs, each a plain digital input or timing latch
// Assumes: One 25 MHz clock; asynchronous active-low reset
// Notes:   Pins pass three flip-flops; a change counts when stages 2 and 3 agree
// How it works
// - Function digit: 0 plain input, 1 latch
// - Edge digit: 0 rising, 1 falling trigger
// - Channel five polarity digit inverts when 1
// - Channel five: separate polarity and function words
// - Channel four has separate function word
// - Channel four polarity digit, 0 positive
`timescale 1ns/1ps
module digital_input_latch_config (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Field pins
   input  wire logic        input_channel_four_i,
   input  wire logic        input_channel_five_i,
   // To capture logic and system
   output logic      [1:0]  di_level_o,
   output logic      [1:0]  latch_event_o,
   output logic             irq_o
);
   logic [15:0] chan_four_polarity_word_q;
   logic [15:0] chan_four_function_word_q;
   logic [15:0] chan_five_polarity_word_q;
   logic [15:0] chan_five_function_word_q;
   logic [1:0]  status_q;
   logic [1:0]  mask_q;
   logic [2:0]  sync4_q;
   logic [2:0]  sync5_q;
   logic [1:0]  stable_q;
   logic [1:0]  level_q;
   logic [1:0]  event_q;
   logic [31:0] rdata_q;
   logic        ack_q;

   // Bus decode
   wire         req       = wb_cyc_i & wb_stb_i & ~ack_q;
   // Writes land at the edge on which the master sees ack
   wire         wr_acc    = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
   wire         wr_lo     = wr_acc & wb_sel_i[0];
   wire         wr_hi     = wr_acc & wb_sel_i[1];
   wire         rd        = req & ~wb_we_i;
   wire         hit_c4p   = wb_adr_i == dlatch_pkg::OFS_CH4_POL;
   wire         hit_c4f   = wb_adr_i == dlatch_pkg::OFS_CH4_FUNC;
   wire         hit_c5p   = wb_adr_i == dlatch_pkg::OFS_CH5_POL;
   wire         hit_c5f   = wb_adr_i == dlatch_pkg::OFS_CH5_FUNC;
   wire         hit_stat  = wb_adr_i == dlatch_pkg::OFS_STATUS;
   wire         hit_mask  = wb_adr_i == dlatch_pkg::OFS_MASK;
   wire         hit_lvl   = wb_adr_i == dlatch_pkg::OFS_LEVEL;
   wire [1:0]   wmask     = {wr_hi, wr_lo};

   // Channel configuration from the setting words
   dlatch_pkg::chan_cfg_t cfg4;
   dlatch_pkg::chan_cfg_t cfg5;
   assign cfg4.pol   = chan_four_polarity_word_q[dlatch_pkg::POL_BIT];
   assign cfg4.latch = chan_four_function_word_q[dlatch_pkg::FUNC_BIT];
   assign cfg4.fall  = chan_four_function_word_q[dlatch_pkg::EDGE_BIT];
   assign cfg5.pol   = chan_five_polarity_word_q[dlatch_pkg::POL_BIT];
   assign cfg5.latch = chan_five_function_word_q[dlatch_pkg::FUNC_BIT];
   assign cfg5.fall  = chan_five_function_word_q[dlatch_pkg::EDGE_BIT];

   // Debounced raw level: only stages 2 and 3 are compared
   wire [1:0]   agree     = {sync5_q[1] ~^ sync5_q[2], sync4_q[1] ~^ sync4_q[2]};
   wire [1:0]   raw_next  = {agree[1] ? sync5_q[2] : stable_q[1],
                             agree[0] ? sync4_q[2] : stable_q[0]};
   wire [1:0]   pol_lvl   = raw_next ^ {cfg5.pol, cfg4.pol};
   wire [1:0]   rise      = pol_lvl & ~level_q;
   wire [1:0]   fall      = ~pol_lvl & level_q;
   wire [1:0]   is_latch  = {cfg5.latch, cfg4.latch};
   wire [1:0]   edge_sel  = {cfg5.fall, cfg4.fall};
   wire [1:0]   event_d   = is_latch & ((~edge_sel & rise) | (edge_sel & fall));
   // Set wins over the read-clear
   wire [1:0]   status_d  = (rd && hit_stat) ? event_d : (status_q | event_d);

   wire [31:0]  rdata_d   = hit_c4p  ? {16'h0000, chan_four_polarity_word_q} :
                            hit_c4f  ? {16'h0000, chan_four_function_word_q} :
                            hit_c5p  ? {16'h0000, chan_five_polarity_word_q} :
                            hit_c5f  ? {16'h0000, chan_five_function_word_q} :
                            hit_stat ? {30'h0, status_q} :
                            hit_mask ? {30'h0, mask_q} :
                            hit_lvl  ? {30'h0, level_q} : 32'h0000_0000;

   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [1:0] m,
                                        input logic [15:0] d);
      wr16 = {m[1] ? d[15:8] : old[15:8], m[0] ? d[7:0] : old[7:0]};
   endfunction : wr16

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         chan_four_polarity_word_q <= dlatch_pkg::WORD_RST;
         chan_four_function_word_q <= dlatch_pkg::WORD_RST;
         chan_five_polarity_word_q <= dlatch_pkg::WORD_RST;
         chan_five_function_word_q <= dlatch_pkg::WORD_RST;
         mask_q                    <= dlatch_pkg::EV_RST;
      end else begin
         // reserved digits are stored as written; software keeps them zero
         if (hit_c4p) chan_four_polarity_word_q <= wr16(chan_four_polarity_word_q, wmask,
                                                        wb_dat_i[15:0]);
         if (hit_c4f) chan_four_function_word_q <= wr16(chan_four_function_word_q, wmask,
                                                        wb_dat_i[15:0]);
         if (hit_c5p) chan_five_polarity_word_q <= wr16(chan_five_polarity_word_q, wmask,
                                                        wb_dat_i[15:0]);
         if (hit_c5f) chan_five_function_word_q <= wr16(chan_five_function_word_q, wmask,
                                                        wb_dat_i[15:0]);
         if (hit_mask && wr_lo) mask_q <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync4_q  <= 3'h0;
         sync5_q  <= 3'h0;
         stable_q <= 2'h0;
         level_q  <= 2'h0;
         event_q  <= 2'h0;
         status_q <= 2'h0;
         ack_q    <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         sync4_q  <= {sync4_q[1:0], input_channel_four_i};
         sync5_q  <= {sync5_q[1:0], input_channel_five_i};
         stable_q <= raw_next;
         level_q  <= pol_lvl;
         event_q  <= event_d;
         status_q <= status_d;
         ack_q    <= req;
         if (rd) rdata_q <= rdata_d;
      end
   end

   assign wb_ack_o      = ack_q;
   assign wb_dat_o      = rdata_q;
   assign di_level_o    = level_q;
   assign latch_event_o = event_q;
   assign irq_o         = |(status_q & mask_q);

   // Checks
   property p_event_one_cycle;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         latch_event_o[0] |=> !latch_event_o[0];
   endproperty
   a_event_one_cycle: assert property (p_event_one_cycle)
      else $error("Event wider than one cycle");

   property p_event_one_cycle5;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         latch_event_o[1] |=> !latch_event_o[1];
   endproperty
   a_event_one_cycle5: assert property (p_event_one_cycle5)
      else $error("Event wider than one cycle");

   property p_plain_no_event4;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         !$past(cfg4.latch) |-> !latch_event_o[0];
   endproperty
   a_plain_no_event4: assert property (p_plain_no_event4)
      else $error("Plain input gave event");

   property p_plain_no_event5;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         !$past(cfg5.latch) |-> !latch_event_o[1];
   endproperty
   a_plain_no_event5: assert property (p_plain_no_event5)
      else $error("Plain input gave event");

   property p_rise4;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (cfg4.latch && !cfg4.fall && !level_q[0] && pol_lvl[0]) |=> latch_event_o[0];
   endproperty
   a_rise4: assert property (p_rise4)
      else $error("Missed rising event");

   property p_rise5;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (cfg5.latch && !cfg5.fall && !level_q[1] && pol_lvl[1]) |=> latch_event_o[1];
   endproperty
   a_rise5: assert property (p_rise5)
      else $error("Missed rising event");

   property p_fall4;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (cfg4.latch && cfg4.fall && level_q[0] && !pol_lvl[0]) |=> latch_event_o[0];
   endproperty
   a_fall4: assert property (p_fall4)
      else $error("Missed falling event");

   property p_fall5;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (cfg5.latch && cfg5.fall && level_q[1] && !pol_lvl[1]) |=> latch_event_o[1];
   endproperty
   a_fall5: assert property (p_fall5)
      else $error("Missed falling event");

   property p_wrong_edge4;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (cfg4.latch && !cfg4.fall && level_q[0] && !pol_lvl[0]) |=> !latch_event_o[0];
   endproperty
   a_wrong_edge4: assert property (p_wrong_edge4)
      else $error("Event on unselected edge");

   property p_wrong_edge5;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (cfg5.latch && cfg5.fall && !level_q[1] && pol_lvl[1]) |=> !latch_event_o[1];
   endproperty
   a_wrong_edge5: assert property (p_wrong_edge5)
      else $error("Event on unselected edge");

   property p_pol5;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         agree[1] |=> (level_q[1] == (stable_q[1] ^ $past(cfg5.pol)));
   endproperty
   a_pol5: assert property (p_pol5)
      else $error("Polarity five wrong");

   property p_pol4;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         1'b1 |=> (level_q[0] == (stable_q[0] ^ $past(cfg4.pol)));
   endproperty
   a_pol4: assert property (p_pol4)
      else $error("Polarity four wrong");

   property p_filter4;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         !agree[0] |=> $stable(stable_q[0]);
   endproperty
   a_filter4: assert property (p_filter4)
      else $error("Unsettled pin changed level");

   sequence s_wr_func4;
      wr_lo && hit_c4f;
   endsequence
   property p_func4_word;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_wr_func4 |=> (chan_four_function_word_q[7:0] == $past(wb_dat_i[7:0]));
   endproperty
   a_func4_word: assert property (p_func4_word)
      else $error("Function word not stored");

   sequence s_wr_func5;
      wr_lo && hit_c5f;
   endsequence
   property p_func5_word;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_wr_func5 |=> (chan_five_function_word_q[7:0] == $past(wb_dat_i[7:0]));
   endproperty
   a_func5_word: assert property (p_func5_word)
      else $error("Function word not stored");

   sequence s_wr_pol4;
      wr_lo && hit_c4p;
   endsequence
   property p_pol4_word;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_wr_pol4 |=> (chan_four_polarity_word_q[7:0] == $past(wb_dat_i[7:0]))
                       && $stable(chan_four_function_word_q);
   endproperty
   a_pol4_word: assert property (p_pol4_word)
      else $error("Polarity word not kept apart");

   sequence s_wr_pol5;
      wr_lo && hit_c5p;
   endsequence
   property p_pol5_word;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_wr_pol5 |=> (chan_five_polarity_word_q[7:0] == $past(wb_dat_i[7:0]))
                       && $stable(chan_five_function_word_q);
   endproperty
   a_pol5_word: assert property (p_pol5_word)
      else $error("Polarity word not kept apart");

   property p_status_set;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (|latch_event_o) |-> ((latch_event_o & ~status_q) == 2'h0);
   endproperty
   a_status_set: assert property (p_status_set)
      else $error("Event left no status bit");

   property p_irq_event;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (|(latch_event_o & mask_q)) |-> irq_o;
   endproperty
   a_irq_event: assert property (p_irq_event)
      else $error("Unmasked event gave no interrupt");

   sequence s_read_status;
      req && !wb_we_i && hit_stat;
   endsequence
   property p_read_clear;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_read_status |=> (wb_dat_o[1:0] == $past(status_q))
                           && ((status_q & ~$past(event_d)) == 2'h0);
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("Status read did not clear");

   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   property p_ack_answer;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_take |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("Request not answered");

   property p_ack_pulse;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("Ack held two cycles");
endmodule : digital_input_latch_config

// ### testbench/field_device.sv
// Purpose: Field device driving the two digital input pins
// Assumes: Push-pull drivers, levels change just after a clock edge
// Notes:   Each level is held long enough to pass the input filter
`timescale 1ns/1ps
module field_device (
   // Clock
   input  wire logic ref_clk_i,
   // Field pins
   output logic      pin4_o,
   output logic      pin5_o
);
   initial begin
      pin4_o = 1'b0;
      pin5_o = 1'b0;
   end
   task automatic drive(input int ch, input logic v);
      @(posedge ref_clk_i);
      if (ch == 4) pin4_o <= v;
      else pin5_o <= v;
      repeat (8) @(posedge ref_clk_i);
   endtask : drive
endmodule : field_device

// ### testbench/digital_input_latch_config_bench.sv
// Purpose: Self-checking bench for the digital input latch block
// Assumes: Wishbone classic master, one idle cycle between requests
// Notes:   Latch events are counted per channel by a monitor
`timescale 1ns/1ps
module digital_input_latch_config_bench;
   logic        ref_clk_i, rstn_i, cyc, stb, we, ack, irq, p4, p5;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, r;
   logic [1:0]  lvl, ev;
   int          n_fail = 0;
   int          checks_done = 0;
   int          ev_cnt [2];
   digital_input_latch_config digital_input_latch_config_inst (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .input_channel_four_i(p4), .input_channel_five_i(p5),
      .di_level_o(lvl), .latch_event_o(ev), .irq_o(irq));
   field_device field_device_inst (.ref_clk_i(ref_clk_i), .pin4_o(p4), .pin5_o(p5));
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
      for (int i = 0; i < 2; i++) if (ev[i] === 1'b1) ev_cnt[i]++;
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do @(posedge ref_clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task pin(input int ch, input logic v);
      ev_cnt[0] = 0;
      ev_cnt[1] = 0;
      field_device_inst.drive(ch, v);
   endtask : pin
   task t_reset;
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
         chk("reset word", r, 32'h0);
      end
      wb(1'b1, 8'h40, 32'h0000_ffff);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", r, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_plain;
      pin(4, 1'b1);
      chk("ch4 level", {31'h0, lvl[0]}, 32'h1);
      chk("ch4 plain event", ev_cnt[0], 32'h0);
      pin(4, 1'b0);
      $display("test plain done");
   endtask : t_plain
   task t_rise;
      wb(1'b1, 8'h14, 32'h0000_0001);
      wb(1'b1, 8'h04, 32'h0000_0001);
      pin(4, 1'b1);
      chk("ch4 rise event", ev_cnt[0], 32'h1);
      chk("irq set", {31'h0, irq}, 32'h1);
      pin(4, 1'b0);
      chk("ch4 fall event", ev_cnt[0], 32'h0);
      wb(1'b0, 8'h10, 32'h0);
      chk("status", r, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      chk("status cleared", r, 32'h0);
      chk("irq clear", {31'h0, irq}, 32'h0);
      $display("test rise done");
   endtask : t_rise
   task t_fall5;
      wb(1'b1, 8'h0c, 32'h0000_0011);
      wb(1'b0, 8'h04, 32'h0);
      chk("ch4 word kept", r, 32'h1);
      pin(5, 1'b1);
      chk("ch5 rise event", ev_cnt[1], 32'h0);
      pin(5, 1'b0);
      chk("ch5 fall event", ev_cnt[1], 32'h1);
      chk("masked irq", {31'h0, irq}, 32'h0);
      wb(1'b0, 8'h10, 32'h0);
      chk("ch5 status", r, 32'h2);
      $display("test fall done");
   endtask : t_fall5
   task t_pol;
      wb(1'b1, 8'h08, 32'h0000_0001);
      wb(1'b1, 8'h00, 32'h0000_0001);
      repeat (8) @(posedge ref_clk_i);
      chk("ch5 inverted", {30'h0, lvl}, 32'h3);
      wb(1'b0, 8'h18, 32'h0);
      chk("level reg", r, 32'h3);
      wb(1'b0, 8'h0c, 32'h0);
      chk("ch5 func word", r, 32'h11);
      $display("test polarity done");
   endtask : t_pol
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   initial begin
      {cyc, stb, we, adr, wdat, rstn_i} = '0;
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_plain();
      t_rise();
      t_fall5();
      t_pol();
      final_report();
   end
   initial begin
      #100000;
      n_fail++;
      final_report();
   end
endmodule : digital_input_latch_config_bench
